// file: dv/afrg_pins_model.sv
`timescale 1ns/100ps
// Far-side controller: ramp pins and the calibration engine answer
module afrg_pins_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic vco_cal_req,
  output logic      step_clock_pin,
  output logic      direction_pin,
  output logic      vco_cal_busy
);
  int cal_len  = 0;
  int busy_cnt = 0;
  initial step_clock_pin = 1'b0;
  initial direction_pin  = 1'b0;
  // Busy for cal_len cycles after a request; zero models an instant calibration
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      busy_cnt <= 0;
    else if (vco_cal_req)
      busy_cnt <= cal_len;
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
  assign vco_cal_busy = busy_cnt > 0;
  // Pulse held several cycles so the synchroniser cannot miss it
  task automatic pulse(input logic dir);
    @(posedge pclk);
    if (dir)
      direction_pin <= 1'b1;
    else
      step_clock_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    direction_pin  <= 1'b0;
    step_clock_pin <= 1'b0;
  endtask
endmodule

// file: dv/afrg_ramp_asserts.sv
`timescale 1ns/100ps
// Port-level checks on the ramp generator top
module afrg_ramp_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        vco_cal_busy,
  input wire logic [31:0] numerator,
  input wire logic        vco_cal_req,
  input wire logic        ramp_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Bus answer: one pulse, one cycle after the access phase opens
  a_ready_timing: assert property (psel && $rose(penable) |=> pready && $past(psel))
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_cause: assert property (pready |-> psel && penable) else $error("pready unasked");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read data");
  // Read data must not wander between reads; software may sample late
  a_read_stable: assert property ($changed(prdata) |-> pready && !pwrite) else $error("prdata moved");
  ////////////////////////////////////////
  // Engine: start calibrates, calibration freezes steps, idle holds numerator
  a_start_cal: assert property ($rose(ramp_active) |-> vco_cal_req) else $error("no start cal");
  a_busy_freeze: assert property (ramp_active && vco_cal_busy |=> $stable(numerator))
    else $error("step during cal");
  a_idle_hold: assert property ($changed(numerator) |-> ramp_active) else $error("idle step");
  a_cal_idle: assert property (vco_cal_req |-> ramp_active) else $error("cal while idle");
endmodule
bind afrg_ramp afrg_ramp_asserts u_chk (.*);

// file: dv/test_automatic_frequency_ramp_generator.sv
`timescale 1ns/100ps
module test_automatic_frequency_ramp_generator;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        pready, pslverr, err, vco_cal_req, vco_cal_busy;
  logic        ramp_active, active_segment, step_clock_pin, direction_pin;
  logic [31:0] prdata, numerator, rd;
  logic [31:0] seed = 32'h00000021;
  int          mismatches = 0;
  int          cmp_count = 0;
  always #10 pclk = ~pclk;
  afrg_ramp DUT (.*);
  afrg_pins_model pm (.*);
  ////////////////////////////////////////
  // Helpers: random source, comparison, bus cycles, expected step
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h00000000);
    check("prdata", rd, e);
    check("pslverr", err, x);
  endtask
  // Saturating add keeps the ramp inside the programmed window
  function automatic logic [33:0] add(logic [33:0] a, logic [29:0] s, logic [33:0] lo, logic [33:0] hi);
    logic signed [33:0] v;
    v = $signed(a) + $signed({{4{s[29]}}, s});
    if (v > $signed(hi)) v = hi;
    if (v < $signed(lo)) v = lo;
    return v;
  endfunction
  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200us;
    mismatches++;
    stop_test();
  end
  ////////////////////////////////////////
  initial
  begin
    logic [33:0] lo, hi, acc, lc;
    logic signed [33:0] d;
    logic [31:0] s, v;
    logic [29:0] st [2];
    logic [15:0] ln [2];
    logic        rs [2];
    logic        seg, ph, h, rq;
    int          cnt, adv;
    logic [3:0]  codes [6];
    codes = '{4'h1, 4'h2, 4'h9, 4'hA, 4'h4, 4'h3};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(afrg_pkg::OFS_LIMLO_LO, 32'h00000001, 1'b0);
    rc(afrg_pkg::OFS_LIMLO_HI, 32'h00000002, 1'b0);
    rc(afrg_pkg::OFS_LIMHI_LO, 32'hFFFFFFFF, 1'b0);
    rc(afrg_pkg::OFS_LIMHI_HI, 32'h00000001, 1'b0);
    rc(afrg_pkg::OFS_DENOM, 32'h00000000, 1'b0);
    rc(8'h44, 32'h00000000, 1'b1);
    wr(afrg_pkg::OFS_DENOM, 32'hFFFFFFFF);
    rc(afrg_pkg::OFS_STATUS, 32'h00000010, 1'b0);
    // Two random two-segment bursts: full range with calibration stall, then halved and clamped
    for (int p = 0; p < 2; p++)
    begin
      h = p[0];
      pm.cal_len = h ? 0 : 3;
      lo = h ? 34'h3FFFFFC00 : 34'h200000001;
      hi = h ? 34'h000000400 : 34'h1FFFFFFFF;
      wr(afrg_pkg::OFS_CTRL, 32'h00000000);
      wr(afrg_pkg::OFS_LIMLO_LO, lo[31:0]);
      wr(afrg_pkg::OFS_LIMLO_HI, {30'h0, lo[33:32]});
      wr(afrg_pkg::OFS_LIMHI_LO, hi[31:0]);
      wr(afrg_pkg::OFS_LIMHI_HI, {30'h0, hi[33:32]});
      for (int i = 0; i < 2; i++)
      begin
        v = rnd();
        ln[i] = 16'(v[21:20]) + 16'h0001;
        st[i] = {{20{v[31]}}, v[9:0]};
        rs[i] = v[24];
        wr(i ? afrg_pkg::OFS_SEG1_CFG : afrg_pkg::OFS_SEG0_CFG, {12'h0, rs[i], 2'b00, ~i[0], ln[i]});
        wr(i ? afrg_pkg::OFS_SEG1_STEP : afrg_pkg::OFS_SEG0_STEP, {2'b00, st[i]});
      end
      wr(afrg_pkg::OFS_TRIG, 32'h00030000);
      wr(afrg_pkg::OFS_THRESH_LO, h ? 32'h00000300 : 32'h00000000);
      s = rnd();
      wr(afrg_pkg::OFS_NUM_START, s);
      wr(afrg_pkg::OFS_CTRL, {27'h0, 1'b1, ~h, h, 2'b01});
      acc = 34'h0;
      lc = 34'h0;
      seg = 1'b0;
      ph = 1'b0;
      cnt = 0;
      adv = 0;
      #1;
      check("numerator", numerator, {2'b00, s});
      check("cal_req", vco_cal_req, 1'b1);
      while (adv < 3)
      begin
        // Decide the coming edge's step from what the design samples there
        rq = 1'b0;
        if ((!h || ph) && !vco_cal_busy)
        begin
          if (cnt == ln[seg])
          begin
            acc = rs[seg] ? 34'h0 : add(acc, st[seg], lo, hi);
            seg = ~seg;
            cnt = 0;
            adv++;
            rq = !h;
          end
          else
          begin
            acc = add(acc, st[seg], lo, hi);
            cnt++;
          end
          d = acc - lc;
          rq |= h && (d >= 34'sh300 || d <= -34'sh300);
          if (rq) lc = acc;
        end
        ph = ~ph;
        @(posedge pclk);
        #1;
        check("numerator", numerator, {2'b00, s + acc[31:0]});
        check("segment", active_segment, seg);
        check("cal_req", vco_cal_req, rq);
      end
      repeat (4) @(posedge pclk);
      check("running", ramp_active, 1'b0);
      apb(1'b0, afrg_pkg::OFS_STATUS, 32'h00000000);
      check("status", rd[1:0], 2'b10);
      rc(afrg_pkg::OFS_CTRL, {28'h0, ~h, h, 2'b01}, 1'b0);
    end
    // Trigger sources: each edge kind advances segment zero, an invalid code never does
    foreach (codes[k])
    begin
      wr(afrg_pkg::OFS_CTRL, 32'h00000000);
      wr(afrg_pkg::OFS_SEG0_CFG, 32'h0003FFFF);
      wr(afrg_pkg::OFS_SEG1_CFG, 32'h0001FFFF);
      wr(afrg_pkg::OFS_TRIG, {28'h0, codes[k]});
      wr(afrg_pkg::OFS_CTRL, 32'h00000011);
      pm.pulse(codes[k][1]);
      repeat (12) @(posedge pclk);
      check("trigger", active_segment, codes[k] != 4'h3);
    end
    stop_test();
  end
endmodule

// file: logic/afrg_pkg.sv
package afrg_pkg;
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_SEG0_CFG   = 8'h04;
  localparam logic [7:0] OFS_SEG0_STEP  = 8'h08;
  localparam logic [7:0] OFS_SEG1_CFG   = 8'h0C;
  localparam logic [7:0] OFS_SEG1_STEP  = 8'h10;
  localparam logic [7:0] OFS_TRIG       = 8'h14;
  localparam logic [7:0] OFS_THRESH_LO  = 8'h18;
  localparam logic [7:0] OFS_THRESH_HI  = 8'h1C;
  localparam logic [7:0] OFS_LIMLO_LO   = 8'h20;
  localparam logic [7:0] OFS_LIMLO_HI   = 8'h24;
  localparam logic [7:0] OFS_LIMHI_LO   = 8'h28;
  localparam logic [7:0] OFS_LIMHI_HI   = 8'h2C;
  localparam logic [7:0] OFS_NUM_START  = 8'h30;
  localparam logic [7:0] OFS_DENOM      = 8'h34;
  localparam logic [7:0] OFS_STATUS     = 8'h38;
  localparam logic [7:0] OFS_NUMERATOR  = 8'h3C;
  localparam logic [7:0] OFS_BURST_CNT  = 8'h40;
  // CTRL field positions
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_MANUAL    = 1;
  localparam int CTRL_HALVE     = 2;
  localparam int CTRL_RECAL_SEG = 3;
  localparam int CTRL_CAL_START = 4;
  // Segment configuration field positions
  localparam int SEG_LEN_LSB    = 0;
  localparam int SEG_SUCC_BIT   = 16;
  localparam int SEG_ADV_LSB    = 17;
  localparam int SEG_RESTORE    = 19;
  // Trigger register field positions
  localparam int TRG_A_LSB      = 0;
  localparam int TRG_B_LSB      = 4;
  localparam int TRG_RPT_LSB    = 8;
  localparam int TRG_BURST_LSB  = 16;
  // Widths
  localparam int LEN_W   = 16;
  localparam int STEP_W  = 30;
  localparam int ACC_W   = 34;
  localparam int BURST_W = 13;
  localparam int SRC_W   = 4;
  // Trigger source codes
  localparam logic [3:0] TSRC_OFF      = 4'h0;
  localparam logic [3:0] TSRC_CLK_RISE = 4'h1;
  localparam logic [3:0] TSRC_DIR_RISE = 4'h2;
  localparam logic [3:0] TSRC_ALWAYS   = 4'h4;
  localparam logic [3:0] TSRC_CLK_FALL = 4'h9;
  localparam logic [3:0] TSRC_DIR_FALL = 4'hA;
  // Advance and burst event codes
  localparam logic [1:0] EVT_LENGTH    = 2'h0;
  localparam logic [1:0] EVT_TRIG_A    = 2'h1;
  localparam logic [1:0] EVT_TRIG_B    = 2'h2;
  // Reset values and fixed values
  localparam logic [31:0] DENOM_FIXED  = 32'hFFFFFFFF;
  localparam logic [31:0] DENOM_RESET  = 32'h00000000;
  localparam logic [33:0] LIMHI_RESET  = 34'h1FFFFFFFF;
  localparam logic [33:0] LIMLO_RESET  = 34'h200000001;
  localparam logic [33:0] THRESH_RESET = 34'h000000000;
endpackage

// file: logic/afrg_ramp.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module afrg_ramp (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        step_clock_pin,
  input  wire logic        direction_pin,
  input  wire logic        vco_cal_busy,
  output logic [31:0]      numerator,
  output logic             vco_cal_req,
  output logic             ramp_active,
  output logic             active_segment
);
  localparam int LEN_W   = afrg_pkg::LEN_W;
  localparam int STEP_W  = afrg_pkg::STEP_W;
  localparam int ACC_W   = afrg_pkg::ACC_W;
  localparam int BURST_W = afrg_pkg::BURST_W;

  // Software-visible configuration
  logic                ramp_enable;
  logic                manual_mode;
  logic                halve_step;
  logic                recal_each_segment;
  logic [LEN_W-1:0]    segment_length [2];
  logic [STEP_W-1:0]   segment_step [2];
  logic                segment_successor [2];
  logic [1:0]          segment_advance_source [2];
  logic                segment_restore [2];
  logic [3:0]          trigger_a_source;
  logic [3:0]          trigger_b_source;
  logic [1:0]          repeat_count_source;
  logic [BURST_W-1:0]  burst_limit;
  logic [ACC_W-1:0]    recal_threshold;
  logic [ACC_W-1:0]    limit_low;
  logic [ACC_W-1:0]    limit_high;
  logic [31:0]         numerator_start;
  logic [31:0]         fraction_denominator;

  // Engine state
  logic                running;
  logic                done;
  logic                phase;
  logic [LEN_W-1:0]    len_cnt;
  logic [ACC_W-1:0]    accum;
  logic [ACC_W-1:0]    last_cal;
  logic [BURST_W-1:0]  burst_cnt;

  afrg_trig_if trg ();

  afrg_trig u_trig (
    .pclk           (pclk),
    .presetn        (presetn),
    .step_clock_pin (step_clock_pin),
    .direction_pin  (direction_pin),
    .trg            (trg.front)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: access completes on the second access-phase cycle
  wire        setup_done = psel & penable & ~pready;
  wire        wr         = psel & penable & pready & pwrite;
  wire        sel_ctrl   = paddr == afrg_pkg::OFS_CTRL;
  wire        sel_s0cfg  = paddr == afrg_pkg::OFS_SEG0_CFG;
  wire        sel_s0stp  = paddr == afrg_pkg::OFS_SEG0_STEP;
  wire        sel_s1cfg  = paddr == afrg_pkg::OFS_SEG1_CFG;
  wire        sel_s1stp  = paddr == afrg_pkg::OFS_SEG1_STEP;
  wire        sel_trig   = paddr == afrg_pkg::OFS_TRIG;
  wire        sel_thlo   = paddr == afrg_pkg::OFS_THRESH_LO;
  wire        sel_thhi   = paddr == afrg_pkg::OFS_THRESH_HI;
  wire        sel_lllo   = paddr == afrg_pkg::OFS_LIMLO_LO;
  wire        sel_llhi   = paddr == afrg_pkg::OFS_LIMLO_HI;
  wire        sel_lhlo   = paddr == afrg_pkg::OFS_LIMHI_LO;
  wire        sel_lhhi   = paddr == afrg_pkg::OFS_LIMHI_HI;
  wire        sel_nstart = paddr == afrg_pkg::OFS_NUM_START;
  wire        sel_den    = paddr == afrg_pkg::OFS_DENOM;
  wire        sel_stat   = paddr == afrg_pkg::OFS_STATUS;
  wire        sel_num    = paddr == afrg_pkg::OFS_NUMERATOR;
  wire        sel_bcnt   = paddr == afrg_pkg::OFS_BURST_CNT;
  wire        hit        = sel_ctrl | sel_s0cfg | sel_s0stp | sel_s1cfg | sel_s1stp | sel_trig | sel_thlo |
                           sel_thhi | sel_lllo | sel_llhi | sel_lhlo | sel_lhhi | sel_nstart | sel_den |
                           sel_stat | sel_num | sel_bcnt;
  wire        den_ok     = fraction_denominator == afrg_pkg::DENOM_FIXED;
  wire [31:0] seg_cfg0   = {12'h000, segment_restore[0], segment_advance_source[0], segment_successor[0],
                            segment_length[0]};
  wire [31:0] seg_cfg1   = {12'h000, segment_restore[1], segment_advance_source[1], segment_successor[1],
                            segment_length[1]};
  wire [31:0] rdata_mux  =
    sel_ctrl   ? {28'h0000000, recal_each_segment, halve_step, manual_mode, ramp_enable} :
    sel_s0cfg  ? seg_cfg0 :
    sel_s0stp  ? {2'h0, segment_step[0]} :
    sel_s1cfg  ? seg_cfg1 :
    sel_s1stp  ? {2'h0, segment_step[1]} :
    sel_trig   ? {3'h0, burst_limit, 6'h00, repeat_count_source, trigger_b_source, trigger_a_source} :
    sel_thlo   ? recal_threshold[31:0] :
    sel_thhi   ? {30'h00000000, recal_threshold[33:32]} :
    sel_lllo   ? limit_low[31:0] :
    sel_llhi   ? {30'h00000000, limit_low[33:32]} :
    sel_lhlo   ? limit_high[31:0] :
    sel_lhhi   ? {30'h00000000, limit_high[33:32]} :
    sel_nstart ? numerator_start :
    sel_den    ? fraction_denominator :
    sel_stat   ? {27'h0000000, den_ok, vco_cal_busy, active_segment, done, running} :
    sel_num    ? numerator :
    sel_bcnt   ? {19'h00000, burst_cnt} :
    32'h00000000;

  // Start uses the values being written, so one write can enable and start
  wire start = wr & sel_ctrl & pwdata[afrg_pkg::CTRL_CAL_START] &
               pwdata[afrg_pkg::CTRL_ENABLE] & ~pwdata[afrg_pkg::CTRL_MANUAL];

  ////////////////////////////////////////////////////////////////////////////
  // Step clock and segment datapath
  wire                tick       = ~halve_step | phase;
  // Enable and mode gate the step at once, so a stopping write never steps or calibrates
  wire                step_ok    = running & ramp_enable & ~manual_mode & tick & ~vco_cal_busy;
  wire                seg        = active_segment;
  wire [STEP_W-1:0]   cur_step   = segment_step[seg];
  wire signed [34:0]  sum_w      = $signed({accum[ACC_W-1], accum}) +
                                   $signed({{5{cur_step[STEP_W-1]}}, cur_step});
  wire signed [34:0]  hi_w       = $signed({limit_high[ACC_W-1], limit_high});
  wire signed [34:0]  lo_w       = $signed({limit_low[ACC_W-1], limit_low});
  wire [ACC_W-1:0]    clamped    = (sum_w > hi_w) ? limit_high :
                                   (sum_w < lo_w) ? limit_low : sum_w[ACC_W-1:0];
  wire [1:0]          adv_code   = segment_advance_source[seg];
  wire                len_done   = len_cnt == segment_length[seg];
  wire                advance    = (adv_code == afrg_pkg::EVT_LENGTH) ? len_done :
                                   (adv_code == afrg_pkg::EVT_TRIG_A) ? trg.fire_a :
                                   (adv_code == afrg_pkg::EVT_TRIG_B) ? trg.fire_b : 1'b0;
  wire                burst_evt  = (repeat_count_source == afrg_pkg::EVT_LENGTH) ? advance :
                                   (repeat_count_source == afrg_pkg::EVT_TRIG_A) ? trg.fire_a :
                                   (repeat_count_source == afrg_pkg::EVT_TRIG_B) ? trg.fire_b :
                                   1'b0;
  wire [BURST_W-1:0]  burst_next = burst_cnt + 13'h0001;
  wire                burst_hit  = (burst_limit != 13'h0000) & burst_evt &
                                   (burst_next == burst_limit);
  wire                restore    = advance & segment_restore[seg];
  wire [ACC_W-1:0]    next_accum = restore ? {ACC_W{1'b0}} : clamped;
  wire signed [34:0]  moved      = $signed({next_accum[ACC_W-1], next_accum}) -
                                   $signed({last_cal[ACC_W-1], last_cal});
  wire [34:0]         moved_abs  = moved[34] ? 35'(-moved) : 35'(moved);
  wire [34:0]         thr_abs    = recal_threshold[ACC_W-1] ?
                                   35'(-$signed({1'b1, recal_threshold})) : {1'b0, recal_threshold};
  wire                thresh_hit = (recal_threshold != {ACC_W{1'b0}}) & (moved_abs >= thr_abs);
  wire                cal_now    = start | (step_ok & (thresh_hit | (advance & recal_each_segment)));

  assign trg.tick  = step_ok;
  assign trg.src_a = trigger_a_source;
  assign trg.src_b = trigger_b_source;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake and read data
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_done;
      pslverr <= setup_done & ~hit;
      if (setup_done & ~pwrite)
        prdata <= rdata_mux;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ramp_enable          <= 1'b0;
      manual_mode          <= 1'b0;
      halve_step           <= 1'b0;
      recal_each_segment   <= 1'b0;
      trigger_a_source     <= afrg_pkg::TSRC_OFF;
      trigger_b_source     <= afrg_pkg::TSRC_OFF;
      repeat_count_source  <= afrg_pkg::EVT_LENGTH;
      burst_limit          <= 13'h0000;
      recal_threshold      <= afrg_pkg::THRESH_RESET;
      limit_low            <= afrg_pkg::LIMLO_RESET;
      limit_high           <= afrg_pkg::LIMHI_RESET;
      numerator_start      <= 32'h00000000;
      fraction_denominator <= afrg_pkg::DENOM_RESET;
    end
    else if (wr)
    begin
      if (sel_ctrl)
      begin
        ramp_enable        <= pwdata[afrg_pkg::CTRL_ENABLE];
        manual_mode        <= pwdata[afrg_pkg::CTRL_MANUAL];
        halve_step         <= pwdata[afrg_pkg::CTRL_HALVE];
        recal_each_segment <= pwdata[afrg_pkg::CTRL_RECAL_SEG];
      end
      if (sel_trig)
      begin
        trigger_a_source    <= pwdata[afrg_pkg::TRG_A_LSB +: 4];
        trigger_b_source    <= pwdata[afrg_pkg::TRG_B_LSB +: 4];
        repeat_count_source <= pwdata[afrg_pkg::TRG_RPT_LSB +: 2];
        burst_limit         <= pwdata[afrg_pkg::TRG_BURST_LSB +: BURST_W];
      end
      if (sel_thlo)   recal_threshold[31:0]  <= pwdata;
      if (sel_thhi)   recal_threshold[33:32] <= pwdata[1:0];
      if (sel_lllo)   limit_low[31:0]        <= pwdata;
      if (sel_llhi)   limit_low[33:32]       <= pwdata[1:0];
      if (sel_lhlo)   limit_high[31:0]       <= pwdata;
      if (sel_lhhi)   limit_high[33:32]      <= pwdata[1:0];
      if (sel_nstart) numerator_start        <= pwdata;
      if (sel_den)    fraction_denominator   <= pwdata;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Two segment register sets, one per generate entry
  for (genvar s = 0; s < 2; s++)
  begin : g_seg
    wire cfg_wr  = wr & (s == 0 ? sel_s0cfg : sel_s1cfg);
    wire step_wr = wr & (s == 0 ? sel_s0stp : sel_s1stp);

    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        segment_length[s]         <= 16'h0000;
        segment_successor[s]      <= 1'b0;
        segment_advance_source[s] <= afrg_pkg::EVT_LENGTH;
        segment_restore[s]        <= 1'b0;
        segment_step[s]           <= 30'h00000000;
      end
      else
      begin
        if (cfg_wr)
        begin
          segment_length[s]         <= pwdata[afrg_pkg::SEG_LEN_LSB +: LEN_W];
          segment_successor[s]      <= pwdata[afrg_pkg::SEG_SUCC_BIT];
          segment_advance_source[s] <= pwdata[afrg_pkg::SEG_ADV_LSB +: 2];
          segment_restore[s]        <= pwdata[afrg_pkg::SEG_RESTORE];
        end
        if (step_wr)
          segment_step[s] <= pwdata[STEP_W-1:0];
      end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate phase; restarted by start so the first step is deterministic
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      phase <= 1'b0;
    else
      phase <= ~start & ~phase;

  ////////////////////////////////////////////////////////////////////////////
  // Ramp engine: segment walk, length count, burst stop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      running        <= 1'b0;
      done           <= 1'b0;
      active_segment <= 1'b0;
      len_cnt        <= 16'h0000;
      burst_cnt      <= 13'h0000;
    end
    else if (start)
    begin
      running        <= 1'b1;
      done           <= 1'b0;
      active_segment <= 1'b0;
      len_cnt        <= 16'h0000;
      burst_cnt      <= 13'h0000;
    end
    else if (~ramp_enable | manual_mode)
      running <= 1'b0;
    else if (step_ok)
    begin
      if (advance)
      begin
        active_segment <= segment_successor[seg];
        len_cnt        <= 16'h0000;
      end
      else if (~len_done)
        len_cnt <= len_cnt + 16'h0001;
      if (burst_evt)
        burst_cnt <= burst_next;
      if (burst_hit)
      begin
        running <= 1'b0;
        done    <= 1'b1;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Numerator accumulator; numerator = start value + ramp offset.
  // Offset is added unscaled, one unit per numerator LSB, so the 32-bit
  // numerator wraps modulo 2^32 like the fractional divider does.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      accum       <= {ACC_W{1'b0}};
      last_cal    <= {ACC_W{1'b0}};
      numerator   <= 32'h00000000;
      vco_cal_req <= 1'b0;
      ramp_active <= 1'b0;
    end
    else
    begin
      vco_cal_req <= cal_now;
      // Drops a cycle after running at a burst stop, so the final step of a burst still reads as active
      ramp_active <= start | (running & ramp_enable & ~manual_mode);
      if (start)
      begin
        accum     <= {ACC_W{1'b0}};
        last_cal  <= {ACC_W{1'b0}};
        numerator <= numerator_start;
      end
      else if (step_ok & ramp_enable & ~manual_mode)
      begin
        accum     <= next_accum;
        numerator <= numerator_start + next_accum[31:0];
        if (cal_now)
          last_cal <= next_accum;
      end
    end
endmodule

// file: logic/afrg_trig.sv
`timescale 1ns/100ps
module afrg_trig (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   step_clock_pin,
  input  wire logic   direction_pin,
  afrg_trig_if.front  trg
);
  logic [1:0] clk_sync;
  logic [1:0] dir_sync;
  logic       clk_prev;
  logic       dir_prev;
  logic [1:0] pend;
  wire        clk_rise = clk_sync[1] & ~clk_prev;
  wire        clk_fall = ~clk_sync[1] & clk_prev;
  wire        dir_rise = dir_sync[1] & ~dir_prev;
  wire        dir_fall = ~dir_sync[1] & dir_prev;
  wire [3:0]  src [2];
  wire [1:0]  edge_now;
  wire [1:0]  fire;

  assign src[0] = trg.src_a;
  assign src[1] = trg.src_b;

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass two flops; only the second stage feeds edge detection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      clk_sync <= 2'h0;
      dir_sync <= 2'h0;
      clk_prev <= 1'b0;
      dir_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], step_clock_pin};
      dir_sync <= {dir_sync[0], direction_pin};
      clk_prev <= clk_sync[1];
      dir_prev <= dir_sync[1];
    end

  ////////////////////////////////////////////////////////////////////////////
  // Per trigger: decode source, hold an edge until the next step tick
  for (genvar i = 0; i < 2; i++)
  begin : g_trig
    assign edge_now[i] = (src[i] == afrg_pkg::TSRC_CLK_RISE) ? clk_rise :
                         (src[i] == afrg_pkg::TSRC_DIR_RISE) ? dir_rise :
                         (src[i] == afrg_pkg::TSRC_CLK_FALL) ? clk_fall :
                         (src[i] == afrg_pkg::TSRC_DIR_FALL) ? dir_fall :
                         1'b0;
    assign fire[i] = trg.tick & ((src[i] == afrg_pkg::TSRC_ALWAYS) | pend[i] | edge_now[i]);

    // An edge landing on a non-tick cycle with halving waits, not lost
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
        pend[i] <= 1'b0;
      else
        pend[i] <= ~trg.tick & (pend[i] | edge_now[i]);
  end

  assign trg.fire_a = fire[0];
  assign trg.fire_b = fire[1];
endmodule

// file: logic/afrg_trig_if.sv
`timescale 1ns/100ps
// Trigger request and answer between the engine and the pin front end
interface afrg_trig_if;
  logic       tick;
  logic [3:0] src_a;
  logic [3:0] src_b;
  logic       fire_a;
  logic       fire_b;
  modport engine (output tick, output src_a, output src_b, input fire_a, input fire_b);
  modport front  (input tick, input src_a, input src_b, output fire_a, output fire_b);
endinterface
